/* design/lif_map.svh */
`ifndef LIF_MAP_SVH
`define LIF_MAP_SVH

// register byte offsets
`define LIF_OFS_CTRL 4'h0
`define LIF_OFS_STAT 4'h4
`define LIF_OFS_CV0 4'h8
`define LIF_OFS_CV1 4'hC

// control register fields
`define LIF_CTRL_PLESIO 0
`define LIF_CTRL_PAR 1
`define LIF_CTRL_REFSEL 2
`define LIF_CTRL_COAX 4
`define LIF_CTRL_MON 6
`define LIF_CTRL_RST 8'h30

// status register fields
`define LIF_STAT_SW 0
`define LIF_STAT_PLESIO 1
`define LIF_STAT_PAR 2
`define LIF_STAT_REFBAD 3
`define LIF_STAT_CMI 4
`define LIF_STAT_MON 6
`define LIF_STAT_LOS 8
`define LIF_STAT_REFSEL 10

// reference frequencies in kHz
`define LIF_F_19M44 18'h04BF0
`define LIF_F_77M76 18'h12FC0
`define LIF_F_155M52 18'h25F80
`define LIF_F_17M408 18'h04400
`define LIF_F_139M264 18'h22000
`define LIF_F_NONE 18'h00000

// bus responses
`define LIF_RESP_OKAY 2'h0
`define LIF_RESP_SLVERR 2'h2

`endif

/* design/lif_pkg.sv */
package lif_pkg;

   typedef enum logic [2:0] {
      LIF_REG_CTRL,
      LIF_REG_STAT,
      LIF_REG_CV0,
      LIF_REG_CV1,
      LIF_REG_NONE
   } lif_reg_t;

   typedef enum logic {
      LIF_HALF_A,
      LIF_HALF_B
   } lif_half_t;

endpackage

/* design/lif_cmi_dec.sv */
`timescale 1ns/10ps
module lif_cmi_dec
   import lif_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic half_stb_i,
   input wire logic half_dat_i,
   input wire logic cmi_mode_i,
   input wire logic resync_i,
   output logic bit_stb_o,
   output logic bit_o,
   output logic viol_o
);

   lif_half_t state_q;
   logic first_q;
   logic expect_high_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= LIF_HALF_A;
         first_q <= 1'b0;
         expect_high_q <= 1'b0;
         bit_stb_o <= 1'b0;
         bit_o <= 1'b0;
         viol_o <= 1'b0;
      end else begin
         bit_stb_o <= 1'b0;
         viol_o <= 1'b0;
         if (!cmi_mode_i) begin
            // nrz: every recovered sample is already one bit
            state_q <= LIF_HALF_A;
            if (half_stb_i) begin
               bit_stb_o <= 1'b1;
               bit_o <= half_dat_i;
            end
         end else if (resync_i) begin
            state_q <= LIF_HALF_A;
         end else if (half_stb_i) begin
            case (state_q)
               LIF_HALF_A: begin
                  first_q <= half_dat_i;
                  state_q <= LIF_HALF_B;
               end
               LIF_HALF_B: begin
                  state_q <= LIF_HALF_A;
                  bit_stb_o <= 1'b1;
                  if (first_q != half_dat_i) begin
                     bit_o <= 1'b0;
                     viol_o <= first_q;
                  end else begin
                     bit_o <= 1'b1;
                     viol_o <= (first_q != expect_high_q);
                     // alternation follows what arrived, so one bad mark costs one flag
                     expect_high_q <= !first_q;
                  end
               end
               default: state_q <= LIF_HALF_A;
            endcase
         end
      end
   end

   sequence s_zero_falling;
      cmi_mode_i && !resync_i && half_stb_i && state_q == LIF_HALF_B && first_q && !half_dat_i;
   endsequence

   sequence s_zero_rising;
      cmi_mode_i && !resync_i && half_stb_i && state_q == LIF_HALF_B && !first_q && half_dat_i;
   endsequence

   property p_zero_falling;
      @(posedge clk_i) disable iff (!rst_n_i) s_zero_falling |=> bit_stb_o && !bit_o && viol_o;
   endproperty
   a_zero_falling: assert property (p_zero_falling) else $error("falling zero not flagged");

   property p_zero_rising;
      @(posedge clk_i) disable iff (!rst_n_i) s_zero_rising |=> bit_stb_o && !bit_o && !viol_o;
   endproperty
   a_zero_rising: assert property (p_zero_rising) else $error("good zero decoded wrongly");

endmodule

/* design/lif_rx_top.sv */
`timescale 1ns/10ps
`include "lif_map.svh"
// Overview of operation
// - select pin low: configuration from pins
// - select pin high: registers, pins ignored
// - rate 1 plesiochronous, 0 synchronous
// - media 1 coax CMI, 0 fiber NRZ
// - software mode: media per channel
// - width select: four-bit parallel or serial
// - synchronous reference: 19.44, 77.76, 155.52 MHz
// - plesiochronous reference: 17.408, none, 139.264 MHz
// - three-level pin maps like register codes
// - receivers accept the selected line rate
// - NRZ bypasses the equalizer
// - recovery PLL reference from reference clock
// - each CMI symbol decodes to one bit
// - violations flagged, decoding never stops
// - three CMI violation cases flagged
// - parallel regroups into nibbles, else serial
// - pin monitors both channels, bit one
// - monitor mode only in CMI mode
// - loss of signal squelches, reference clock out
// - loss indicator only in CMI mode
module lif_rx_top
   import lif_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire logic SERIAL_PORT_SELECT_I,
   input wire logic RATE_SELECT_PIN_I,
   input wire logic MEDIA_SELECT_PIN_I,
   input wire logic INTERFACE_WIDTH_PIN_I,
   input wire logic MONITOR_MODE_PIN_I,
   input wire logic [1:0] REFCLK_FREQ_SELECT_I,
   input wire logic REFERENCE_CLOCK_I,
   input wire logic [1:0] RX_HALF_TGL_I,
   input wire logic [1:0] RX_HALF_DAT_I,
   input wire logic [1:0] SIGNAL_LOSS_I,
   output logic PLESIO_RATE_O,
   output logic PARALLEL_MODE_O,
   output logic [17:0] DPLL_REF_KHZ_O,
   output logic REF_SEL_BAD_O,
   output logic [1:0] CMI_MODE_O,
   output logic [1:0] EQ_BYPASS_O,
   output logic [1:0] MON_EN_O,
   output logic [1:0] SIGNAL_LOSS_FLAG_O,
   output logic [1:0] CODE_VIOLATION_FLAG_O,
   output logic [1:0] RX_SDAT_O,
   output logic [1:0] RX_SCLK_O,
   output logic [7:0] RX_PDAT_O,
   output logic [1:0] RX_PCLK_O,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [3:0] AWADDR_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   output logic BVALID_O,
   input wire logic BREADY_I,
   output logic [1:0] BRESP_O,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   input wire logic [3:0] ARADDR_I,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O
);

   function automatic lif_reg_t lif_decode(input logic [3:0] addr);
      case (addr)
         `LIF_OFS_CTRL: lif_decode = LIF_REG_CTRL;
         `LIF_OFS_STAT: lif_decode = LIF_REG_STAT;
         `LIF_OFS_CV0: lif_decode = LIF_REG_CV0;
         `LIF_OFS_CV1: lif_decode = LIF_REG_CV1;
         default: lif_decode = LIF_REG_NONE;
      endcase
   endfunction

   function automatic logic [17:0] lif_ref_khz(input logic e4, input logic [1:0] sel);
      case ({e4, sel})
         3'h0: lif_ref_khz = `LIF_F_19M44;
         3'h2: lif_ref_khz = `LIF_F_77M76;
         3'h3: lif_ref_khz = `LIF_F_155M52;
         3'h4: lif_ref_khz = `LIF_F_17M408;
         3'h7: lif_ref_khz = `LIF_F_139M264;
         default: lif_ref_khz = `LIF_F_NONE;
      endcase
   endfunction

   // every pin is asynchronous to MCLK_I
   logic [13:0] pin_raw;
   logic [13:0] meta_q;
   logic [13:0] sync_q;
   logic [1:0] tgl_d_q;
   logic [1:0] half_stb;

   assign pin_raw = {SERIAL_PORT_SELECT_I, RATE_SELECT_PIN_I, MEDIA_SELECT_PIN_I, INTERFACE_WIDTH_PIN_I,
                     MONITOR_MODE_PIN_I, REFCLK_FREQ_SELECT_I, REFERENCE_CLOCK_I, RX_HALF_TGL_I,
                     RX_HALF_DAT_I, SIGNAL_LOSS_I};

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         meta_q <= 14'h0000;
         sync_q <= 14'h0000;
         tgl_d_q <= 2'h0;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
         tgl_d_q <= sync_q[5:4];
      end
   end

   assign half_stb = sync_q[5:4] ^ tgl_d_q;

   // software registers
   logic [7:0] ctrl_q;
   logic [15:0] cv_cnt_q [2];

   // effective configuration
   logic sw_mode;
   logic rate_eff;
   logic par_eff;
   logic [1:0] refsel_eff;
   logic [1:0] cmi_eff;
   logic [1:0] mon_eff;
   logic [1:0] los_eff;

   always_comb begin
      sw_mode = sync_q[13];
      rate_eff = sw_mode ? ctrl_q[`LIF_CTRL_PLESIO] : sync_q[12];
      par_eff = sw_mode ? ctrl_q[`LIF_CTRL_PAR] : sync_q[10];
      // pad encodes the three-level pin as low 00, float 10, high 11
      refsel_eff = sw_mode ? ctrl_q[`LIF_CTRL_REFSEL +: 2] : sync_q[8:7];
      for (int ch = 0; ch < 2; ch++) begin
         cmi_eff[ch] = sw_mode ? ctrl_q[`LIF_CTRL_COAX + ch] : sync_q[11];
         mon_eff[ch] = cmi_eff[ch] && (sw_mode ? ctrl_q[`LIF_CTRL_MON + ch] : sync_q[9]);
         los_eff[ch] = cmi_eff[ch] && sync_q[ch];
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         PLESIO_RATE_O <= 1'b0;
         PARALLEL_MODE_O <= 1'b0;
         DPLL_REF_KHZ_O <= `LIF_F_19M44;
         REF_SEL_BAD_O <= 1'b0;
         CMI_MODE_O <= 2'h0;
         EQ_BYPASS_O <= 2'h3;
         MON_EN_O <= 2'h0;
         SIGNAL_LOSS_FLAG_O <= 2'h0;
      end else begin
         PLESIO_RATE_O <= rate_eff;
         PARALLEL_MODE_O <= par_eff;
         DPLL_REF_KHZ_O <= lif_ref_khz(rate_eff, refsel_eff);
         REF_SEL_BAD_O <= (lif_ref_khz(rate_eff, refsel_eff) == `LIF_F_NONE);
         CMI_MODE_O <= cmi_eff;
         EQ_BYPASS_O <= ~cmi_eff;
         MON_EN_O <= mon_eff;
         SIGNAL_LOSS_FLAG_O <= los_eff;
      end
   end

   // symbol decoding, one decoder per channel
   logic [1:0] bit_stb;
   logic [1:0] bit_val;
   logic [1:0] viol;

   for (genvar g = 0; g < 2; g++) begin : g_dec
      lif_cmi_dec u_dec (
         .clk_i(MCLK_I),
         .rst_n_i(NRST_I),
         .half_stb_i(half_stb[g]),
         .half_dat_i(sync_q[2 + g]),
         .cmi_mode_i(cmi_eff[g]),
         .resync_i(los_eff[g]),
         .bit_stb_o(bit_stb[g]),
         .bit_o(bit_val[g]),
         .viol_o(viol[g])
      );
   end

   // violation pulses and counters; a pulse in the clearing cycle counts as one
   logic [1:0] cv_clr;

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         CODE_VIOLATION_FLAG_O <= 2'h0;
         cv_cnt_q[0] <= 16'h0000;
         cv_cnt_q[1] <= 16'h0000;
      end else begin
         for (int ch = 0; ch < 2; ch++) begin
            CODE_VIOLATION_FLAG_O[ch] <= viol[ch] && cmi_eff[ch] && !los_eff[ch];
            if (viol[ch] && cmi_eff[ch] && !los_eff[ch]) begin
               if (cv_clr[ch]) begin
                  cv_cnt_q[ch] <= 16'h0001;
               end else if (cv_cnt_q[ch] != 16'hFFFF) begin
                  cv_cnt_q[ch] <= cv_cnt_q[ch] + 16'h0001;
               end
            end else if (cv_clr[ch]) begin
               cv_cnt_q[ch] <= 16'h0000;
            end
         end
      end
   end

   // system side hand-off
   logic [2:0] shift_q [2];
   logic [1:0] nib_cnt_q [2];

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         RX_SDAT_O <= 2'h0;
         RX_SCLK_O <= 2'h3;
         RX_PDAT_O <= 8'h00;
         RX_PCLK_O <= 2'h3;
         for (int ch = 0; ch < 2; ch++) begin
            shift_q[ch] <= 3'h0;
            nib_cnt_q[ch] <= 2'h0;
         end
      end else begin
         for (int ch = 0; ch < 2; ch++) begin
            if (los_eff[ch]) begin
               // the substitute clock only follows the sampled reference; its rate is bounded by MCLK_I
               RX_SDAT_O[ch] <= 1'b0;
               RX_PDAT_O[ch * 4 +: 4] <= 4'h0;
               RX_SCLK_O[ch] <= !par_eff ? sync_q[6] : 1'b1;
               RX_PCLK_O[ch] <= par_eff ? sync_q[6] : 1'b1;
               nib_cnt_q[ch] <= 2'h0;
            end else if (par_eff) begin
               RX_SDAT_O[ch] <= 1'b0;
               RX_SCLK_O[ch] <= 1'b1;
               RX_PCLK_O[ch] <= 1'b1;
               if (bit_stb[ch]) begin
                  shift_q[ch] <= {shift_q[ch][1:0], bit_val[ch]};
                  nib_cnt_q[ch] <= nib_cnt_q[ch] + 2'h1;
                  if (nib_cnt_q[ch] == 2'h3) begin
                     RX_PDAT_O[ch * 4 +: 4] <= {shift_q[ch], bit_val[ch]};
                     RX_PCLK_O[ch] <= 1'b0;
                  end
               end
            end else begin
               RX_PDAT_O[ch * 4 +: 4] <= 4'h0;
               RX_PCLK_O[ch] <= 1'b1;
               nib_cnt_q[ch] <= 2'h0;
               // low for one cycle with new data, data is stable at the rising edge
               RX_SCLK_O[ch] <= !bit_stb[ch];
               if (bit_stb[ch]) begin
                  RX_SDAT_O[ch] <= bit_val[ch];
               end
            end
         end
      end
   end

   // register bus: write path
   logic aw_got_q;
   logic w_got_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   lif_reg_t wr_reg;

   assign wr_fire = aw_got_q && w_got_q && !BVALID_O;
   assign wr_reg = lif_decode(aw_addr_q);
   assign cv_clr[0] = wr_fire && wr_reg == LIF_REG_CV0;
   assign cv_clr[1] = wr_fire && wr_reg == LIF_REG_CV1;

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         AWREADY_O <= 1'b0;
         WREADY_O <= 1'b0;
         BVALID_O <= 1'b0;
         BRESP_O <= `LIF_RESP_OKAY;
      end else begin
         if (AWVALID_I && AWREADY_O) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= AWADDR_I;
            AWREADY_O <= 1'b0;
         end else begin
            AWREADY_O <= !aw_got_q && !BVALID_O && !wr_fire;
         end
         if (WVALID_I && WREADY_O) begin
            w_got_q <= 1'b1;
            w_data_q <= WDATA_I;
            w_strb_q <= WSTRB_I;
            WREADY_O <= 1'b0;
         end else begin
            WREADY_O <= !w_got_q && !BVALID_O && !wr_fire;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            BVALID_O <= 1'b1;
            BRESP_O <= (wr_reg == LIF_REG_NONE) ? `LIF_RESP_SLVERR : `LIF_RESP_OKAY;
         end else if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         ctrl_q <= `LIF_CTRL_RST;
      end else if (wr_fire && wr_reg == LIF_REG_CTRL && w_strb_q[0]) begin
         ctrl_q <= w_data_q[7:0];
      end
   end

   // register bus: read path
   logic [31:0] stat_word;

   always_comb begin
      stat_word = 32'h00000000;
      stat_word[`LIF_STAT_SW] = sw_mode;
      stat_word[`LIF_STAT_PLESIO] = rate_eff;
      stat_word[`LIF_STAT_PAR] = par_eff;
      stat_word[`LIF_STAT_REFBAD] = (lif_ref_khz(rate_eff, refsel_eff) == `LIF_F_NONE);
      stat_word[`LIF_STAT_CMI +: 2] = cmi_eff;
      stat_word[`LIF_STAT_MON +: 2] = mon_eff;
      stat_word[`LIF_STAT_LOS +: 2] = los_eff;
      stat_word[`LIF_STAT_REFSEL +: 2] = refsel_eff;
   end

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         ARREADY_O <= 1'b0;
         RVALID_O <= 1'b0;
         RDATA_O <= 32'h00000000;
         RRESP_O <= `LIF_RESP_OKAY;
      end else begin
         if (ARVALID_I && ARREADY_O) begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b1;
            RRESP_O <= `LIF_RESP_OKAY;
            case (lif_decode(ARADDR_I))
               LIF_REG_CTRL: RDATA_O <= {24'h000000, ctrl_q};
               LIF_REG_STAT: RDATA_O <= stat_word;
               LIF_REG_CV0: RDATA_O <= {16'h0000, cv_cnt_q[0]};
               LIF_REG_CV1: RDATA_O <= {16'h0000, cv_cnt_q[1]};
               default: begin
                  RDATA_O <= 32'h00000000;
                  RRESP_O <= `LIF_RESP_SLVERR;
               end
            endcase
         end else begin
            if (RVALID_O && RREADY_I) begin
               RVALID_O <= 1'b0;
            end
            ARREADY_O <= !RVALID_O;
         end
      end
   end

   // checks
   property p_hw_rate;
      @(posedge MCLK_I) disable iff (!NRST_I)
         $past(NRST_I) && !$past(sync_q[13]) |-> PLESIO_RATE_O == $past(sync_q[12]);
   endproperty
   a_hw_rate: assert property (p_hw_rate) else $error("pin mode rate mismatch");

   property p_sw_rate;
      @(posedge MCLK_I) disable iff (!NRST_I)
         $past(NRST_I) && $past(sync_q[13]) |-> PLESIO_RATE_O == $past(ctrl_q[`LIF_CTRL_PLESIO]);
   endproperty
   a_sw_rate: assert property (p_sw_rate) else $error("register mode rate mismatch");

   property p_ref_155;
      @(posedge MCLK_I) disable iff (!NRST_I)
         !rate_eff && refsel_eff == 2'h3 |=> DPLL_REF_KHZ_O == `LIF_F_155M52;
   endproperty
   a_ref_155: assert property (p_ref_155) else $error("wrong 155 reference");

   property p_ref_none;
      @(posedge MCLK_I) disable iff (!NRST_I)
         rate_eff && refsel_eff == 2'h2 |=> REF_SEL_BAD_O && DPLL_REF_KHZ_O == `LIF_F_NONE;
   endproperty
   a_ref_none: assert property (p_ref_none) else $error("float setting not invalid at e4");

   property p_eq_bypass;
      @(posedge MCLK_I) disable iff (!NRST_I) EQ_BYPASS_O == ~CMI_MODE_O;
   endproperty
   a_eq_bypass: assert property (p_eq_bypass) else $error("equalizer bypass wrong");

   property p_mon_nrz;
      @(posedge MCLK_I) disable iff (!NRST_I) (MON_EN_O & ~CMI_MODE_O) == 2'h0;
   endproperty
   a_mon_nrz: assert property (p_mon_nrz) else $error("monitor active in nrz");

   property p_los_nrz;
      @(posedge MCLK_I) disable iff (!NRST_I) (SIGNAL_LOSS_FLAG_O & ~CMI_MODE_O) == 2'h0;
   endproperty
   a_los_nrz: assert property (p_los_nrz) else $error("loss flag in nrz");

   property p_squelch;
      @(posedge MCLK_I) disable iff (!NRST_I) (SIGNAL_LOSS_FLAG_O & RX_SDAT_O) == 2'h0;
   endproperty
   a_squelch: assert property (p_squelch) else $error("data not squelched");

   property p_cv_pulse;
      @(posedge MCLK_I) disable iff (!NRST_I)
         CODE_VIOLATION_FLAG_O[0] |=> !CODE_VIOLATION_FLAG_O[0];
   endproperty
   a_cv_pulse: assert property (p_cv_pulse) else $error("violation flag longer than one cycle");

   property p_par_idle;
      @(posedge MCLK_I) disable iff (!NRST_I) !PARALLEL_MODE_O |-> RX_PDAT_O == 8'h00 && RX_PCLK_O == 2'h3;
   endproperty
   a_par_idle: assert property (p_par_idle) else $error("parallel outputs active in serial");

   property p_bresp_hold;
      @(posedge MCLK_I) disable iff (!NRST_I) BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

endmodule

/* tb/lif_line_model.sv */
`timescale 1ns/10ps
module lif_line_model (
   input wire logic clk_i,
   output logic [1:0] tgl_o,
   output logic [1:0] dat_o
);
   initial begin
      tgl_o = 2'h0;
      dat_o = 2'h3;
   end
   // one half every five clocks keeps well clear of the receiver's two-cycle toggle limit
   task automatic send_half(input int ch, input logic v);
      @(posedge clk_i);
      dat_o[ch] <= v;
      @(posedge clk_i);
      tgl_o[ch] <= ~tgl_o[ch];
      repeat (3) @(posedge clk_i);
      // the level is not held past its half, so a stale value cannot pass for data
      dat_o[ch] <= ~v;
   endtask
   // first half goes out first, as the line carries it
   task automatic send_sym(input int ch, input logic [1:0] s);
      send_half(ch, s[1]);
      send_half(ch, s[0]);
   endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
`include "lif_map.svh"
module tb_top;
   import lif_pkg::*;
   logic clk = 0, rst_n = 0, spsel = 0, rate_p = 0, media_p = 0, width_p = 0, mon_p = 0, refclk = 0;
   logic [1:0] refsel = 2'h0, signal_loss_flag = 2'h0, tgl, dat;
   logic plesio, par, ref_bad;
   logic [17:0] fref;
   logic [1:0] cmi, eq, mon, losf, cvf, sdat, sclk, pclk, b_resp, r_resp;
   logic [7:0] pdat;
   logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
   logic [3:0] aw_a = 4'h0, ar_a = 4'h0, w_s = 4'hF;
   logic [31:0] w_d = 32'h0, r_d, rd;
   logic [1:0] rsp;
   logic [15:0] sbits = 16'h0;
   logic [7:0] nib = 8'h0;
   int nbits = 0, nviol = 0, nb1 = 0, err_total = 0, n_compared = 0;
   logic [17:0] fexp [0:5] = '{`LIF_F_19M44, `LIF_F_77M76, `LIF_F_155M52, `LIF_F_17M408, `LIF_F_NONE, `LIF_F_139M264};
   logic [1:0] sels [0:2] = '{2'h0, 2'h2, 2'h3};

   always #12.5 clk = ~clk;
   always #100 refclk = ~refclk;

   lif_rx_top dut_u (.MCLK_I(clk), .NRST_I(rst_n), .SERIAL_PORT_SELECT_I(spsel), .RATE_SELECT_PIN_I(rate_p),
      .MEDIA_SELECT_PIN_I(media_p), .INTERFACE_WIDTH_PIN_I(width_p), .MONITOR_MODE_PIN_I(mon_p),
      .REFCLK_FREQ_SELECT_I(refsel), .REFERENCE_CLOCK_I(refclk), .RX_HALF_TGL_I(tgl), .RX_HALF_DAT_I(dat),
      .SIGNAL_LOSS_I(signal_loss_flag), .PLESIO_RATE_O(plesio), .PARALLEL_MODE_O(par), .DPLL_REF_KHZ_O(fref),
      .REF_SEL_BAD_O(ref_bad), .CMI_MODE_O(cmi), .EQ_BYPASS_O(eq), .MON_EN_O(mon), .SIGNAL_LOSS_FLAG_O(losf),
      .CODE_VIOLATION_FLAG_O(cvf), .RX_SDAT_O(sdat), .RX_SCLK_O(sclk), .RX_PDAT_O(pdat), .RX_PCLK_O(pclk),
      .AWVALID_I(aw_v), .AWREADY_O(aw_rdy), .AWADDR_I(aw_a), .WVALID_I(w_v), .WREADY_O(w_rdy), .WDATA_I(w_d),
      .WSTRB_I(w_s), .BVALID_O(b_v), .BREADY_I(b_r), .BRESP_O(b_resp), .ARVALID_I(ar_v), .ARREADY_O(ar_rdy),
      .ARADDR_I(ar_a), .RVALID_O(r_v), .RREADY_I(r_r), .RDATA_O(r_d), .RRESP_O(r_resp));

   lif_line_model line_u (.clk_i(clk), .tgl_o(tgl), .dat_o(dat));

   // receive-side observer, sampling what the outputs held before each edge
   always @(posedge clk) begin
      if (sclk[0] === 1'b0) begin
         sbits <= {sbits[14:0], sdat[0]};
         nbits++;
      end
      if (cvf[0] === 1'b1) nviol++;
      // channel 1 strobes, serial or parallel, whichever mode is active
      if (sclk[1] === 1'b0 || pclk[1] === 1'b0) nb1++;
      if (pclk[0] === 1'b0) nib <= {nib[3:0], pdat[3:0]};
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      r = 2'h3;
      @(posedge clk);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      while (n < 100) begin
         @(posedge clk);
         n++;
         if (aw_v && aw_rdy === 1'b1) aw_v <= 1'b0;
         if (w_v && w_rdy === 1'b1) w_v <= 1'b0;
         if (b_v === 1'b1) begin
            r = b_resp;
            b_r <= 1'b0;
            break;
         end
      end
      if (n >= 100) chk(32'h1, 32'h0);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      d = 32'hX;
      r = 2'h3;
      @(posedge clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      while (n < 100) begin
         @(posedge clk);
         n++;
         if (ar_v && ar_rdy === 1'b1) ar_v <= 1'b0;
         if (r_v === 1'b1) begin
            d = r_d;
            r = r_resp;
            r_r <= 1'b0;
            break;
         end
      end
      if (n >= 100) chk(32'h1, 32'h0);
   endtask

   task automatic t_reset;
      chk(eq, 2'h3);
      chk({losf, cvf, mon}, 6'h0);
      axi_rd(`LIF_OFS_CTRL, rd, rsp);
      chk(rd, 32'h30);
      chk(rsp, `LIF_RESP_OKAY);
      axi_rd(4'h2, rd, rsp);
      chk(rsp, `LIF_RESP_SLVERR);
      $display("test reset done");
   endtask

   task automatic t_pins;
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 3; k++) begin
            rate_p <= r[0];
            refsel <= sels[k];
            media_p <= 1'b1;
            width_p <= 1'b1;
            repeat (6) @(posedge clk);
            chk(fref, fexp[r * 3 + k]);
            chk(ref_bad, fexp[r * 3 + k] == `LIF_F_NONE);
            chk(plesio, r[0]);
            chk({cmi, eq, par}, 5'h19);
         end
      end
      $display("test pins done");
   endtask

   task automatic t_soft;
      spsel <= 1'b1;
      axi_wr(`LIF_OFS_CTRL, 32'hD8, rsp);
      chk(rsp, `LIF_RESP_OKAY);
      repeat (6) @(posedge clk);
      chk({plesio, par}, 2'h0);
      chk(fref, `LIF_F_77M76);
      chk({cmi, eq}, 4'h6);
      chk(mon, 2'h1);
      axi_rd(`LIF_OFS_CTRL, rd, rsp);
      chk(rd, 32'hD8);
      axi_rd(`LIF_OFS_STAT, rd, rsp);
      chk(rd[0], 1'b1);
      nb1 = 0;
      line_u.send_half(1, 1'b1);
      repeat (4) @(posedge clk);
      chk(sdat[1], 1'b1);
      line_u.send_half(1, 1'b0);
      repeat (4) @(posedge clk);
      chk(sdat[1], 1'b0);
      chk(nb1, 2);
      $display("test software mode done");
   endtask

   task automatic t_cmi;
      logic [1:0] syms [0:4] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h3};
      nbits = 0;
      nviol = 0;
      for (int i = 0; i < 5; i++) line_u.send_sym(0, syms[i]);
      repeat (10) @(posedge clk);
      chk(nbits, 5);
      chk(sbits[4:0], 5'h0D);
      chk(nviol, 2);
      axi_rd(`LIF_OFS_CV0, rd, rsp);
      chk(rd, 32'h2);
      axi_wr(`LIF_OFS_CV0, 32'h0, rsp);
      axi_rd(`LIF_OFS_CV0, rd, rsp);
      chk(rd, 32'h0);
      $display("test cmi decode done");
   endtask

   task automatic t_loss_par;
      logic [1:0] syms [0:7] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h1, 2'h3, 2'h1};
      logic seen_lo, seen_hi;
      seen_lo = 1'b0;
      seen_hi = 1'b0;
      axi_wr(`LIF_OFS_CTRL, 32'h1A, rsp);
      repeat (6) @(posedge clk);
      chk(par, 1'b1);
      signal_loss_flag <= 2'h3;
      repeat (8) @(posedge clk);
      chk(losf, 2'h1);
      repeat (40) begin
         @(posedge clk);
         chk(pdat[3:0], 4'h0);
         if (pclk[0] === 1'b0) seen_lo = 1'b1;
         if (pclk[0] === 1'b1) seen_hi = 1'b1;
      end
      chk({seen_lo, seen_hi}, 2'h3);
      signal_loss_flag <= 2'h0;
      repeat (8) @(posedge clk);
      nviol = 0;
      for (int i = 0; i < 8; i++) line_u.send_sym(0, syms[i]);
      repeat (10) @(posedge clk);
      chk(nib, 8'hB2);
      chk(nviol, 0);
      nb1 = 0;
      for (int i = 0; i < 4; i++) line_u.send_half(1, i == 0 || i == 3);
      repeat (4) @(posedge clk);
      chk(pdat[7:4], 4'h9);
      chk(nb1, 1);
      $display("test loss and parallel done");
   endtask

   task automatic t_monpin;
      spsel <= 1'b0;
      media_p <= 1'b1;
      mon_p <= 1'b1;
      repeat (6) @(posedge clk);
      chk(mon, 2'h3);
      media_p <= 1'b0;
      signal_loss_flag <= 2'h3;
      repeat (6) @(posedge clk);
      chk({mon, cmi, eq}, 6'h03);
      chk(losf, 2'h0);
      $display("test monitor pin done");
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #(25 * 20000);
      err_total++;
      finish_test;
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_pins;
      t_soft;
      t_cmi;
      t_loss_par;
      t_monpin;
      finish_test;
   end
endmodule
